// ---- core/sleep_wake_regs.svh ----
// Purpose: offsets, field positions, reset values and timing counts of the sleep controller
// Assumes: word-indexed plain register port
// Notes:   included by bare name
`ifndef SLEEP_WAKE_REGS_SVH
`define SLEEP_WAKE_REGS_SVH
`define SWC_ADDR_W          4
`define SWC_OFF_REGCTL      4'h0
`define SWC_OFF_STATUS      4'h1
`define SWC_OFF_WAKECFG     4'h2
`define SWC_REGCTL_RESET    8'h01
`define SWC_REGCTL_LP_BIT   1
`define SWC_REGCTL_RSV_BIT  0
`define SWC_ST_TO_BIT       4
`define SWC_ST_PD_BIT       3
`define SWC_ST_SLEEP_BIT    0
`define SWC_ST_LPACT_BIT    1
`define SWC_ST_WDT_BIT      2
`define SWC_OST_PERIODS     1024
`define SWC_LP_STAB_NS      2000
`define SWC_CLK_NS          40
`define SWC_LP_STAB_CYC     ((`SWC_LP_STAB_NS + `SWC_CLK_NS - 1) / `SWC_CLK_NS)
`endif

// ---- core/sleep_wake_pkg.sv ----
// Purpose: types of the sleep controller
// Assumes: nothing
// Notes:   constants live in sleep_wake_regs.svh
`default_nettype none
package sleep_wake_pkg;
    typedef enum logic [3:0] {
        ST_AWAKE = 4'h1,
        ST_SLEEP = 4'h2,
        ST_OST   = 4'h4,
        ST_STAB  = 4'h8
    } pwr_state_t;
    typedef struct packed {
        logic       lowPowerSel;
        logic       statusTo;
        logic       statusPd;
    } sw_regs_t;
    typedef struct packed {
        logic       wdtClear;
        logic       wdtRun;
        logic       cpuClkEn;
        logic       lfoscRun;
        logic       t1Run;
        logic       adcRun;
        logic       hfoscRun;
        logic       portHold;
        logic       regLowPower;
    } pwr_ctl_t;
endpackage : sleep_wake_pkg
`default_nettype wire

// ---- core/wake_delay_counter.sv ----
// Purpose: loadable down counter for start-up and stabilisation waits
// Assumes: load is a synchronous one-cycle pulse; tick is a synchronous enable that may stay high for many cycles
// Notes:   done is high while the count is zero
`default_nettype none
module wake_delay_counter #(
    parameter int W = 11
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         load,
    input  wire logic [W-1:0] loadValue,
    input  wire logic         tick,
    output logic              done
);
    typedef struct packed {
        logic [W-1:0] count;
    } cnt_state_t;
    cnt_state_t state_q;
    cnt_state_t state_d;

    if (W < 2) begin : g_bad_w
        $error("wake_delay_counter: W too small");
    end

    always_comb begin
        state_d = state_q;
        if (load) begin
            state_d.count = loadValue;
        end else if (tick && state_q.count != '0) begin
            state_d.count = state_q.count - W'(1);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign done = (state_q.count == '0);
endmodule : wake_delay_counter
`default_nettype wire

// ---- core/sleep_wake_controller.sv ----
// Purpose: sleep entry, wake and regulator mode control for a small core
// Assumes: core, interrupt and reset sources synchronous to clk
// Notes:   full-reset wake sources arrive as hardware reset and end sleep here too
`default_nettype none
`include "sleep_wake_regs.svh"
// Behaviour
// (RULE1) Sleep is entered only on the core's sleep instruction.
// (RULE2) Watchdog cleared on entry; runs in sleep only if configured so.
// (RULE3) Completed entry clears power_down_flag and sets timeout_flag.
// (RULE4) CPU clock gated in sleep; low_freq_int_osc keeps running.
// (RULE5) Timer1 runs in sleep from low_freq_int_osc, timer1_ext_clk_in or its oscillator.
// (RULE6) Converter runs on through sleep when clocked by adc_rc_osc.
// (RULE7) Port pins hold their pre-sleep state during sleep.
// (RULE8) Non-watchdog resets act the same in sleep as awake.
// (RULE9) Wake on resets, watchdog, external or sleep-capable peripheral interrupt.
// (RULE10) Core prefetches next instruction while executing sleep.
// (RULE11) Interrupt wakes only if individually enabled, whatever global_int_enable.
// (RULE12) After interrupt wake run prefetched op, then vector if global enable.
// (RULE13) Watchdog cleared on every wake.
// (RULE14) Enabled flag already set: sleep is a no-op, flags and watchdog untouched.
// (RULE15) Flag set during or after sleep: complete, wake at once, clear watchdog.
// (RULE16) Crystal oscillator wake waits 1024 periods; other modes skip it. The code also skips it in crystal mode when twoSpeedStart is set.
// (RULE17) regulator_lowpower_sel puts regulator in low power during sleep.
// (RULE18) Low-power sleep adds stabilisation delay on wake.
// (RULE19) Regulator stays normal while a low-power-incompatible peripheral is active.
// (RULE20) Reserved regulator bit resets to 1 and reads 1.
// (RULE21) high_freq_int_osc may stay on in sleep for the waveform unit.
// (RULE22) Sleep-active output drops the cycle after wake once delays end.
module sleep_wake_controller #(
    parameter int NUM_IRQ      = 8,
    parameter int OST_PERIODS  = `SWC_OST_PERIODS,
    parameter int STAB_CYCLES  = `SWC_LP_STAB_CYC
) (
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic                   sleepInstr,
    input  wire logic [NUM_IRQ-1:0]     irqFlags,
    input  wire logic [NUM_IRQ-1:0]     irqEnables,
    input  wire logic                   globalIntEnable,
    input  wire logic                   wdtTimeout,
    input  wire logic                   wdtRunInSleep,
    input  wire logic                   crystalOsc,
    input  wire logic                   twoSpeedStart,
    input  wire logic                   oscTick,
    input  wire logic                   t1Enable,
    input  wire logic                   t1SleepSrc,
    input  wire logic                   adcBusy,
    input  wire logic                   adcOnRcOsc,
    input  wire logic                   lpIncompatActive,
    input  wire logic                   cwgUsesHfosc,
    input  wire logic [`SWC_ADDR_W-1:0] regAddr,
    input  wire logic [7:0]             regWdata,
    input  wire logic                   regWrite,
    input  wire logic                   regRead,
    output logic [7:0]                  regRdata,
    output logic                        sleepActive,
    output logic                        prefetchNext,
    output logic                        resumePulse,
    output logic                        vectorIsr,
    output logic                        wdtWakeStatus,
    output sleep_wake_pkg::pwr_ctl_t    pwrCtl
);
    localparam int OST_W  = $clog2(OST_PERIODS + 1) + 1;
    localparam int STAB_W = $clog2(STAB_CYCLES + 1) + 1;
    localparam int CNT_W  = (OST_W > STAB_W) ? OST_W : STAB_W;

    if (NUM_IRQ < 1) begin : g_bad_irq
        $error("sleep_wake_controller: NUM_IRQ must be at least 1");
    end
    if (OST_PERIODS < 1) begin : g_bad_ost
        $error("sleep_wake_controller: OST_PERIODS must be positive");
    end
    if (STAB_CYCLES < 1) begin : g_bad_stab
        $error("sleep_wake_controller: STAB_CYCLES must be positive");
    end

    typedef struct packed {
        sleep_wake_pkg::pwr_state_t fsm;
        sleep_wake_pkg::sw_regs_t   regs;
        logic                       irqWake;
        logic                       wdtWoke;
        logic                       stabPending;
        logic                       lpInSleep;

        logic [7:0]                 rdata;
        logic                       sleepOut;
        logic                       prefetch;
        logic                       resume;
        logic                       vector;
        sleep_wake_pkg::pwr_ctl_t   ctl;
    } ctl_state_t;

    ctl_state_t state_q;
    ctl_state_t state_d;

    logic                   cntLoad;
    logic [CNT_W-1:0]       cntValue;
    logic                   cntTick;
    logic                   cntDone;

    function automatic logic anyEnabled(input logic [NUM_IRQ-1:0] f,
                                        input logic [NUM_IRQ-1:0] e);
        anyEnabled = |(f & e);
    endfunction : anyEnabled

    function automatic logic [7:0] regRead8(input sleep_wake_pkg::sw_regs_t r,
                                            input logic [`SWC_ADDR_W-1:0] a,
                                            input sleep_wake_pkg::pwr_state_t f,
                                            input logic lp,
                                            input logic wdtW);
        regRead8 = 8'h00;

        case (a)
            `SWC_OFF_REGCTL: begin
                regRead8[`SWC_REGCTL_LP_BIT]  = r.lowPowerSel;
                regRead8[`SWC_REGCTL_RSV_BIT] = 1'b1; // see RULE20
            end
            `SWC_OFF_STATUS: begin
                regRead8[`SWC_ST_TO_BIT]    = r.statusTo;
                regRead8[`SWC_ST_PD_BIT]    = r.statusPd;
                regRead8[`SWC_ST_SLEEP_BIT] = (f != sleep_wake_pkg::ST_AWAKE);
                regRead8[`SWC_ST_LPACT_BIT] = lp;
                regRead8[`SWC_ST_WDT_BIT]   = wdtW;
            end
            default: regRead8 = 8'h00;
        endcase
    endfunction : regRead8

    logic irqPending;
    logic wakeEvent;
    // wake ignores global_int_enable; it only steers the vector
    assign irqPending = anyEnabled(irqFlags, irqEnables); // see RULE11
    assign wakeEvent  = irqPending || wdtTimeout; // see RULE9

    always_comb begin
        state_d         = state_q;
        state_d.resume  = 1'b0;
        state_d.vector  = 1'b0;
        state_d.prefetch = 1'b0;
        cntLoad         = 1'b0;
        cntValue        = '0;
        cntTick         = 1'b0;
        state_d.ctl.wdtClear = 1'b0;

        if (regWrite && regAddr == `SWC_OFF_REGCTL) begin
            state_d.regs.lowPowerSel = regWdata[`SWC_REGCTL_LP_BIT]; // see RULE17
        end

        state_d.rdata = regRead8(state_q.regs, regAddr, state_q.fsm,
                                 state_q.lpInSleep, state_q.wdtWoke);

        case (state_q.fsm)
            sleep_wake_pkg::ST_AWAKE: begin
                if (sleepInstr) begin // see RULE1
                    if (irqPending) begin
                        state_d.irqWake = 1'b0; // see RULE14
                    end else begin
                        state_d.fsm           = sleep_wake_pkg::ST_SLEEP;
                        state_d.regs.statusPd = 1'b0; // see RULE3
                        state_d.regs.statusTo = 1'b1; // see RULE3
                        state_d.ctl.wdtClear  = 1'b1; // see RULE2
                        state_d.prefetch      = 1'b1; // see RULE10
                        state_d.sleepOut      = 1'b1;
                        state_d.wdtWoke       = 1'b0;
                        state_d.lpInSleep     = state_q.regs.lowPowerSel
                                                && !lpIncompatActive; // see RULE19
                    end
                end
            end

            sleep_wake_pkg::ST_SLEEP: begin
                state_d.lpInSleep = state_q.regs.lowPowerSel && !lpIncompatActive; // see RULE19

                if (wakeEvent) begin // see RULE15
                    state_d.irqWake      = irqPending;
                    state_d.wdtWoke      = wdtTimeout && !irqPending;
                    state_d.ctl.wdtClear = 1'b1; // see RULE13
                    state_d.stabPending  = state_q.lpInSleep; // see RULE18
                    state_d.lpInSleep    = 1'b0;

                    if (crystalOsc && !twoSpeedStart) begin // see RULE16
                        state_d.fsm = sleep_wake_pkg::ST_OST;
                        cntLoad     = 1'b1;
                        cntValue    = CNT_W'(OST_PERIODS);
                    end else if (state_q.lpInSleep) begin
                        state_d.fsm = sleep_wake_pkg::ST_STAB;
                        cntLoad     = 1'b1;
                        cntValue    = CNT_W'(STAB_CYCLES);
                    end else begin
                        state_d.fsm      = sleep_wake_pkg::ST_AWAKE;
                        state_d.sleepOut = 1'b0; // see RULE22
                        state_d.resume   = 1'b1;
                        state_d.vector   = irqPending && globalIntEnable; // see RULE12
                    end
                end
            end

            sleep_wake_pkg::ST_OST: begin
                state_d.ctl.wdtClear = 1'b1; // watchdog held clear until start-up ends
                cntTick = oscTick;

                if (cntDone) begin
                    if (state_q.stabPending) begin
                        state_d.fsm = sleep_wake_pkg::ST_STAB;
                        cntLoad     = 1'b1;
                        cntValue    = CNT_W'(STAB_CYCLES);
                    end else begin
                        state_d.fsm      = sleep_wake_pkg::ST_AWAKE;
                        state_d.sleepOut = 1'b0; // see RULE22
                        state_d.resume   = 1'b1;
                        state_d.vector   = state_q.irqWake && globalIntEnable; // see RULE12
                    end
                end
            end

            sleep_wake_pkg::ST_STAB: begin
                cntTick = 1'b1; // see RULE18

                if (cntDone) begin
                    state_d.fsm         = sleep_wake_pkg::ST_AWAKE;
                    state_d.stabPending = 1'b0;
                    state_d.sleepOut    = 1'b0; // see RULE22
                    state_d.resume      = 1'b1;
                    state_d.vector      = state_q.irqWake && globalIntEnable; // see RULE12
                end
            end

            default: begin
                state_d.fsm      = sleep_wake_pkg::ST_AWAKE;
                state_d.sleepOut = 1'b0;
            end
        endcase

        // clock and domain enables follow the state being entered
        state_d.ctl.cpuClkEn    = !state_d.sleepOut; // see RULE4
        state_d.ctl.lfoscRun    = 1'b1; // see RULE4

        state_d.ctl.wdtRun      = !state_d.sleepOut || wdtRunInSleep; // see RULE2
        state_d.ctl.t1Run       = t1Enable && (!state_d.sleepOut || t1SleepSrc); // see RULE5
        state_d.ctl.adcRun      = adcBusy && (!state_d.sleepOut || adcOnRcOsc); // see RULE6
        state_d.ctl.hfoscRun    = !state_d.sleepOut || cwgUsesHfosc; // see RULE21

        state_d.ctl.portHold    = state_d.sleepOut; // see RULE7
        state_d.ctl.regLowPower = state_d.lpInSleep && state_d.sleepOut; // see RULE17
    end

    // other resets reach this block only through reset_n, in sleep as awake; see RULE8
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q                  <= '0;

            state_q.fsm              <= sleep_wake_pkg::ST_AWAKE;
            state_q.regs.statusPd    <= 1'b1;
            state_q.regs.statusTo    <= 1'b1;

            state_q.ctl.cpuClkEn     <= 1'b1;
            state_q.ctl.lfoscRun     <= 1'b1;
            state_q.ctl.wdtRun       <= 1'b1;
            state_q.ctl.hfoscRun     <= 1'b1;
            state_q.ctl.wdtClear     <= 1'b1; // see RULE9
        end else begin
            state_q <= state_d;
        end
    end

    wake_delay_counter #(
        .W (CNT_W)
    ) u_delay (
        .clk       (clk),
        .reset_n   (reset_n),
        .load      (cntLoad),
        .loadValue (cntValue),
        .tick      (cntTick),
        .done      (cntDone)
    );

    assign regRdata      = state_q.rdata;
    assign sleepActive   = state_q.sleepOut;
    assign prefetchNext  = state_q.prefetch;
    assign resumePulse   = state_q.resume;
    assign vectorIsr     = state_q.vector;
    assign wdtWakeStatus = state_q.wdtWoke;
    assign pwrCtl        = state_q.ctl;

    property pEntry;
        @(posedge clk) disable iff (!reset_n)
        (state_q.fsm == sleep_wake_pkg::ST_AWAKE && sleepInstr && !irqPending)
            |=> (sleepActive && !state_q.regs.statusPd && state_q.regs.statusTo
                 && pwrCtl.wdtClear && !pwrCtl.cpuClkEn);
    endproperty
    AST_ENTRY: assert property (pEntry) else $error("sleep entry effects missing"); // see RULE3

    AST_NOP_SLEEP: assert property (@(posedge clk) disable iff (!reset_n) // see RULE14
        (state_q.fsm == sleep_wake_pkg::ST_AWAKE && sleepInstr && irqPending)
            |=> (!sleepActive && $stable(state_q.regs) && !pwrCtl.wdtClear))
        else $error("sleep with pending irq was not a no-op");

    AST_ONLY_INSTR: assert property (@(posedge clk) disable iff (!reset_n) // see RULE1
        $rose(sleepActive) |-> $past(sleepInstr))
        else $error("sleep entered without instruction");

    // the waits after wake keep sleepActive high too
    sequence sFastWake;
        state_q.fsm == sleep_wake_pkg::ST_SLEEP && wakeEvent
            && !state_q.lpInSleep && !(crystalOsc && !twoSpeedStart);
    endsequence
    AST_FAST_WAKE: assert property (@(posedge clk) disable iff (!reset_n) // see RULE22
        sFastWake |=> (!sleepActive && resumePulse && pwrCtl.wdtClear && pwrCtl.cpuClkEn))
        else $error("fast wake not taken next cycle");

    AST_VECTOR: assert property (@(posedge clk) disable iff (!reset_n) // see RULE12
        vectorIsr |-> (resumePulse && globalIntEnable))
        else $error("vector without global enable");

    AST_CLK_GATED: assert property (@(posedge clk) disable iff (!reset_n) // see RULE4
        sleepActive |-> (!pwrCtl.cpuClkEn && pwrCtl.lfoscRun && pwrCtl.portHold))
        else $error("cpu clock not gated in sleep");

    AST_REG_LP: assert property (@(posedge clk) disable iff (!reset_n) // see RULE17
        pwrCtl.regLowPower |-> (sleepActive && state_q.regs.lowPowerSel))
        else $error("regulator low power outside allowed case");

    AST_RSV_BIT: assert property (@(posedge clk) disable iff (!reset_n) // see RULE20
        (regRead && regAddr == `SWC_OFF_REGCTL) |=> regRdata[`SWC_REGCTL_RSV_BIT])
        else $error("reserved bit read as 0");

    AST_STAB_LEN: assert property (@(posedge clk) disable iff (!reset_n) // see RULE18
        (sleepActive && wakeEvent && state_q.lpInSleep && !crystalOsc)
            |=> sleepActive [*2])
        else $error("low-power wake skipped stabilisation");

    AST_WAKE_WDT_CLR: assert property (@(posedge clk) disable iff (!reset_n) // see RULE13
        (state_q.fsm == sleep_wake_pkg::ST_SLEEP && wakeEvent)
            |=> pwrCtl.wdtClear)
        else $error("watchdog not cleared on wake");

    AST_LP_BLOCKED: assert property (@(posedge clk) disable iff (!reset_n) // see RULE19
        (state_q.fsm == sleep_wake_pkg::ST_SLEEP && lpIncompatActive)
            |=> !pwrCtl.regLowPower)
        else $error("low-power regulator beside incompatible peripheral");
endmodule : sleep_wake_controller
`default_nettype wire

// ---- testbench/osc_tick_model.sv ----
// Purpose: oscillator partner, gives start-up ticks to the sleep controller
// Assumes: ticks run only while the controller reports sleep, start-up wait or stabilisation wait
// Notes:   DIV shortens a real crystal period so the run stays short
`default_nettype none
module osc_tick_model #(
    parameter int DIV = 3
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        running,
    output logic             oscTick,
    output logic [15:0]      tickCount
);
    timeunit 1ns;
    timeprecision 1ns;
    int divCount_q;
    // the oscillator is stopped while the core runs, so no stray ticks reach the wait counter
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            divCount_q <= 0;
            oscTick <= 1'b0;
            tickCount <= 16'h0;
        end else if (running) begin
            divCount_q <= (divCount_q == DIV - 1) ? 0 : divCount_q + 1;
            oscTick <= (divCount_q == DIV - 1);
            tickCount <= tickCount + 16'((divCount_q == DIV - 1) ? 1 : 0);
        end else begin
            divCount_q <= 0;
            oscTick <= 1'b0;
        end
    end
endmodule : osc_tick_model
`default_nettype wire

// ---- testbench/tb_sleep_wake_controller.sv ----
// Purpose: self-checking bench of the sleep and wake controller
// Assumes: shortened start-up and stabilisation counts
// Notes:   after the time-zero values, all inputs change by non-blocking assignment at the rising edge
`default_nettype none
`include "sleep_wake_regs.svh"
module tb_sleep_wake_controller;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int OST  = 4;
    localparam int STAB = 3;
    logic        clk, reset_n, sleepInstr, globalIntEnable, wdtTimeout, wdtRunInSleep;
    logic        crystalOsc, twoSpeedStart, oscTick, t1Enable, t1SleepSrc, adcBusy;
    logic        adcOnRcOsc, lpIncompatActive, cwgUsesHfosc, regWrite, regRead;
    logic [7:0]  irqFlags, irqEnables, regWdata, regRdata, rd;
    logic [`SWC_ADDR_W-1:0] regAddr;
    logic        sleepActive, prefetchNext, resumePulse, vectorIsr, wdtWakeStatus;
    logic [15:0] tickCount, base;
    sleep_wake_pkg::pwr_ctl_t pwrCtl;
    int          err_total, n_compared, cycles, n;

    sleep_wake_controller #(.NUM_IRQ(8), .OST_PERIODS(OST), .STAB_CYCLES(STAB))
    sleep_wake_controller_inst (.clk(clk), .reset_n(reset_n), .sleepInstr(sleepInstr),
        .irqFlags(irqFlags), .irqEnables(irqEnables), .globalIntEnable(globalIntEnable),
        .wdtTimeout(wdtTimeout), .wdtRunInSleep(wdtRunInSleep), .crystalOsc(crystalOsc),
        .twoSpeedStart(twoSpeedStart), .oscTick(oscTick), .t1Enable(t1Enable),
        .t1SleepSrc(t1SleepSrc), .adcBusy(adcBusy), .adcOnRcOsc(adcOnRcOsc),
        .lpIncompatActive(lpIncompatActive), .cwgUsesHfosc(cwgUsesHfosc),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .sleepActive(sleepActive), .prefetchNext(prefetchNext),
        .resumePulse(resumePulse), .vectorIsr(vectorIsr), .wdtWakeStatus(wdtWakeStatus),
        .pwrCtl(pwrCtl));
    osc_tick_model #(.DIV(3)) osc_tick_model_inst (.clk(clk), .reset_n(reset_n),
        .running(sleepActive), .oscTick(oscTick), .tickCount(tickCount));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ceiling well above the hundred or so cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total = err_total + 1;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [`SWC_ADDR_W-1:0] a, input logic [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr
    // read data follow the address one cycle later and stand while it is held; the strobe is not used
    task automatic rdReg(input logic [`SWC_ADDR_W-1:0] a, output logic [7:0] d);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 d = regRdata;
        @(posedge clk);
    endtask : rdReg
    task automatic sleepNow();
        sleepInstr <= 1'b1;
        @(posedge clk);
        sleepInstr <= 1'b0;
        #1;
    endtask : sleepNow
    task automatic waitResume(output int c);
        c = 0;
        do begin
            @(posedge clk);
            #1 c++;
        end while (resumePulse !== 1'b1 && c < 200);
        chk("resume seen", 16'(resumePulse), 16'h1);
    endtask : waitResume

    initial begin
        cycles = 0;
        err_total = 0;
        n_compared = 0;
        reset_n = 1'b0;
        {sleepInstr, globalIntEnable, wdtTimeout, wdtRunInSleep, crystalOsc} = 5'h0;
        {twoSpeedStart, t1Enable, t1SleepSrc, adcBusy, adcOnRcOsc} = 5'h0;
        {lpIncompatActive, cwgUsesHfosc, regWrite, regRead} = 4'h0;
        {irqFlags, irqEnables, regWdata, regAddr} = '0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rdReg(`SWC_OFF_REGCTL, rd);
        chk("regctl reset", 16'(rd), 16'h01);
        rdReg(`SWC_OFF_STATUS, rd);
        chk("status reset", 16'(rd), 16'h18);
        wr(`SWC_OFF_REGCTL, 8'h00);
        rdReg(`SWC_OFF_REGCTL, rd);
        chk("reserved bit", 16'(rd), 16'h01);
        wr(`SWC_OFF_STATUS, 8'hFF);
        rdReg(`SWC_OFF_STATUS, rd);
        chk("status read only", 16'(rd), 16'h18);
        rdReg(4'hF, rd);
        chk("unmapped", 16'(rd), 16'h00);
        $display("test registers done");
        irqFlags <= 8'h01;
        irqEnables <= 8'h01;
        sleepNow();
        chk("noop active", 16'(sleepActive), 16'h0);
        chk("noop prefetch", 16'(prefetchNext), 16'h0);
        chk("noop wdt clear", 16'(pwrCtl.wdtClear), 16'h0);
        @(posedge clk);
        irqFlags <= 8'h00;
        rdReg(`SWC_OFF_STATUS, rd);
        chk("noop status", 16'(rd), 16'h18);
        $display("test pending interrupt done");
        for (int i = 0; i < 2; i++) begin
            {wdtRunInSleep, t1SleepSrc, adcOnRcOsc, cwgUsesHfosc} <= {4{i == 0}};
            {t1Enable, adcBusy, globalIntEnable} <= {1'b1, 1'b1, i == 1};
            irqEnables <= 8'h04;
            sleepNow();
            chk("asleep", 16'(sleepActive), 16'h1);
            chk("prefetch", 16'(prefetchNext), 16'h1);
            chk("entry wdt clear", 16'(pwrCtl.wdtClear), 16'h1);
            chk("wdt run", 16'(pwrCtl.wdtRun), 16'(i == 0));
            chk("cpu clock", 16'(pwrCtl.cpuClkEn), 16'h0);
            chk("lf osc", 16'(pwrCtl.lfoscRun), 16'h1);
            chk("timer1", 16'(pwrCtl.t1Run), 16'(i == 0));
            chk("converter", 16'(pwrCtl.adcRun), 16'(i == 0));
            chk("port hold", 16'(pwrCtl.portHold), 16'h1);
            chk("hf osc", 16'(pwrCtl.hfoscRun), 16'(i == 0));
            @(posedge clk);
            rdReg(`SWC_OFF_STATUS, rd);
            chk("sleep status", 16'(rd), 16'h11);
            irqFlags <= 8'h02;
            repeat (3) @(posedge clk);
            #1 chk("masked source", 16'(sleepActive), 16'h1);
            @(posedge clk);
            irqFlags <= 8'h06;
            waitResume(n);
            chk("fast wake", 16'(n), 16'h1);
            chk("awake", 16'(sleepActive), 16'h0);
            chk("vector", 16'(vectorIsr), 16'(i == 1));
            chk("wake wdt clear", 16'(pwrCtl.wdtClear), 16'h1);
            @(posedge clk);
            irqFlags <= 8'h00;
            rdReg(`SWC_OFF_STATUS, rd);
            chk("wake status", 16'(rd), 16'h10);
        end
        $display("test interrupt wake done");
        sleepNow();
        @(posedge clk);
        wdtTimeout <= 1'b1;
        waitResume(n);
        chk("wdt wake", 16'(wdtWakeStatus), 16'h1);
        chk("wdt no vector", 16'(vectorIsr), 16'h0);
        @(posedge clk);
        wdtTimeout <= 1'b0;
        rdReg(`SWC_OFF_STATUS, rd);
        chk("wdt status", 16'(rd), 16'h14);
        $display("test watchdog wake done");
        wr(`SWC_OFF_REGCTL, 8'h03);
        sleepNow();
        chk("low power", 16'(pwrCtl.regLowPower), 16'h1);
        @(posedge clk);
        lpIncompatActive <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("lp blocked", 16'(pwrCtl.regLowPower), 16'h0);
        @(posedge clk);
        lpIncompatActive <= 1'b0;
        @(posedge clk);
        irqFlags <= 8'h04;
        waitResume(n);
        chk("lp delay", 16'(n), 16'(STAB + 2));
        $display("test low power done");
        for (int j = 0; j < 2; j++) begin
            @(posedge clk);
            irqFlags <= 8'h00;
            crystalOsc <= 1'b1;
            twoSpeedStart <= (j == 1);
            if (j == 1) wr(`SWC_OFF_REGCTL, 8'h01);
            sleepNow();
            base = tickCount;
            @(posedge clk);
            irqFlags <= 8'h04;
            waitResume(n);
            if (j == 0) chk("start ticks", 16'(tickCount - base >= OST), 16'h1);
            else chk("two speed", 16'(n), 16'h1);
        end
        @(posedge clk);
        {irqFlags, crystalOsc, twoSpeedStart} <= '0;
        $display("test crystal wake done");
        sleepNow();
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        #1 chk("reset wake", 16'(sleepActive), 16'h0);
        chk("reset clock", 16'(pwrCtl.cpuClkEn), 16'h1);
        @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rdReg(`SWC_OFF_STATUS, rd);
        chk("status after reset", 16'(rd), 16'h18);
        $display("test reset in sleep done");
        report_and_stop();
    end
endmodule : tb_sleep_wake_controller
`default_nettype wire
